// *** hw/i2cms_pkg.sv ***
package i2cms_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] I2CMS_CTRL_OFS = 8'h00;
	localparam logic [7:0] I2CMS_STAT_OFS = 8'h04;
	localparam logic [7:0] I2CMS_IEN_OFS = 8'h08;
	localparam logic [7:0] I2CMS_ICLR_OFS = 8'h0C;
	localparam logic [7:0] I2CMS_TXD_OFS = 8'h10;
	localparam logic [7:0] I2CMS_DIV_OFS = 8'h14;
	// control field positions
	localparam int I2CMS_CTRL_MM_BIT = 0;
	localparam int I2CMS_CTRL_TR_BIT = 1;
	localparam int I2CMS_CTRL_STT_BIT = 2;
	localparam int I2CMS_CTRL_STP_BIT = 3;
	localparam int I2CMS_CTRL_GIE_BIT = 4;
	// status / flag field positions
	localparam int I2CMS_F_STT = 0;
	localparam int I2CMS_F_STP = 1;
	localparam int I2CMS_F_NACK = 2;
	localparam int I2CMS_F_TXE = 3;
	localparam int I2CMS_NFLAGS = 4;
	localparam int I2CMS_BUSY_BIT = 8;
	localparam int I2CMS_TXFULL_BIT = 9;
	// reset values
	localparam logic [15:0] I2CMS_DIV_RST = 16'h00FF;
	localparam logic [3:0] I2CMS_IEN_RST = 4'h0;
	localparam logic [3:0] I2CMS_FLAG_RST = 4'h8;
	// master sequencer states, one-hot
	typedef enum logic [4:0] {
		I2CMS_IDLE = 5'b0_0001,
		I2CMS_WAIT = 5'b0_0010,
		I2CMS_STA = 5'b0_0100,
		I2CMS_XFER = 5'b0_1000,
		I2CMS_STO = 5'b1_0000
	} i2cms_state_t;
	// bus line samples carried together
	typedef struct packed {
		logic scl;
		logic sda;
	} i2cms_line_t;
endpackage : i2cms_pkg

// *** hw/i2cms_mon.sv ***
`timescale 1ns/100ps
`default_nettype none
// bus monitor: synchronises scl/sda and finds start, stop, edges, busy
module i2cms_mon
	import i2cms_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire i2cms_line_t line_in,
	output i2cms_line_t line_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det,
	output logic bus_busy
);
	i2cms_line_t meta_reg, meta_next; // first stage, read only by sync
	i2cms_line_t sync_reg, sync_next;
	i2cms_line_t last_reg, last_next;
	logic busy_reg, busy_next;
	////////////////////////////////////////////////////////////////////////
	// next values
	always_comb begin
		meta_next = line_in;
		sync_next = meta_reg;
		last_next = sync_reg;
		busy_next = busy_reg;
		if (start_det) begin
			busy_next = 1'b1;
		end else if (stop_det) begin
			busy_next = 1'b0;
		end
	end
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '{scl: 1'b1, sda: 1'b1};
			sync_reg <= '{scl: 1'b1, sda: 1'b1};
			last_reg <= '{scl: 1'b1, sda: 1'b1};
			busy_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			last_reg <= last_next;
			busy_reg <= busy_next;
		end
	end
	// conditions from the synchronised copies only
	assign line_s = sync_reg;
	assign scl_rise = sync_reg.scl & ~last_reg.scl;
	assign scl_fall = ~sync_reg.scl & last_reg.scl;
	assign start_det = sync_reg.scl & last_reg.scl & last_reg.sda
		& ~sync_reg.sda;
	assign stop_det = sync_reg.scl & last_reg.scl & ~last_reg.sda
		& sync_reg.sda;
	assign bus_busy = busy_reg;
endmodule : i2cms_mon
`default_nettype wire

// *** hw/i2cms_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE_01: busy bus in multi-master transmit waits release
// RULE_02: start request reads one until start sent
// RULE_03: software loads data only after start clears
// RULE_04: start, stop, nack flags hardware-cleared too
// RULE_05: interrupt pending when flag and enable set; irq output here also needs global enable
// RULE_06: software drops local enables around global enable
// RULE_07: software keeps bus clock low for repeats
// RULE_08: waiting ignores bus traffic, keeps transmit data
module i2cms_top
	import i2cms_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic irq
);
	i2cms_line_t ls; // synchronised lines
	logic scl_rise, scl_fall, start_det, stop_det, bus_busy;
	i2cms_mon u_mon (
		.pclk(pclk),
		.presetn(presetn),
		.line_in('{scl: scl_in, sda: sda_in}),
		.line_s(ls),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det),
		.bus_busy(bus_busy)
	);
	////////////////////////////////////////////////////////////////////////
	// register and sequencer state
	logic mm_reg, mm_next; // multi_master_select
	logic tr_reg, tr_next; // transmitter_role
	logic stt_reg, stt_next; // start_request
	logic stp_reg, stp_next; // stop request
	logic gie_reg, gie_next; // global_irq_enable
	logic [3:0] ien_reg, ien_next; // local_irq_enable
	logic [3:0] flg_reg, flg_next; // local_irq_flag
	logic [7:0] txb_reg, txb_next; // transmit_buffer
	logic txf_reg, txf_next; // buffer holds unsent byte
	logic [15:0] div_reg, div_next; // half bit period in pclk, less one
	logic [15:0] cnt_reg, cnt_next;
	i2cms_state_t st_reg, st_next;
	logic [3:0] bit_reg, bit_next; // 0..7 data, 8 ack
	logic [7:0] sh_reg, sh_next;
	logic ph_reg, ph_next; // 0 low half, 1 high half
	logic sclo_reg, sclo_next, sdao_reg, sdao_next;
	logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next; // pin drivers
	logic [31:0] rd_reg, rd_next;
	logic irq_reg, irq_next;
	logic wr, rd, tick;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign tick = (cnt_reg == 16'h0000);
	// read mux, sampled in setup so data stands in access
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		rd_mux = 32'h0000_0000;
		case (a)
			I2CMS_CTRL_OFS: rd_mux = {27'h000_0000, gie_reg, stp_reg,
				stt_reg, tr_reg, mm_reg}; // RULE_02
			I2CMS_STAT_OFS: rd_mux = {22'h00_0000, txf_reg, bus_busy,
				4'h0, flg_reg};
			I2CMS_IEN_OFS: rd_mux = {28'h000_0000, ien_reg};
			I2CMS_TXD_OFS: rd_mux = {24'h00_0000, txb_reg};
			I2CMS_DIV_OFS: rd_mux = {16'h0000, div_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	endfunction : rd_mux
	////////////////////////////////////////////////////////////////////////
	// next state: registers, flags, sequencer
	always_comb begin
		mm_next = mm_reg;
		tr_next = tr_reg;
		stt_next = stt_reg;
		stp_next = stp_reg;
		gie_next = gie_reg;
		ien_next = ien_reg;
		flg_next = flg_reg;
		txb_next = txb_reg;
		txf_next = txf_reg;
		div_next = div_reg;
		st_next = st_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		ph_next = ph_reg;
		sclo_next = sclo_reg;
		sdao_next = sdao_reg;
		cnt_next = tick ? div_reg : cnt_reg - 16'h0001;
		rd_next = rd ? rd_mux(paddr) : rd_reg;
		// software writes first, hardware events below win
		if (wr) begin
			case (paddr)
				I2CMS_CTRL_OFS: begin
					mm_next = pwdata[I2CMS_CTRL_MM_BIT];
					tr_next = pwdata[I2CMS_CTRL_TR_BIT];
					stt_next = stt_reg | pwdata[I2CMS_CTRL_STT_BIT];
					stp_next = stp_reg | pwdata[I2CMS_CTRL_STP_BIT];
					gie_next = pwdata[I2CMS_CTRL_GIE_BIT];
				end
				I2CMS_IEN_OFS: ien_next = pwdata[3:0];
				I2CMS_ICLR_OFS: flg_next = flg_reg & ~pwdata[3:0]; // RULE_04
				I2CMS_TXD_OFS: begin
					txb_next = pwdata[7:0];
					txf_next = 1'b1;
					flg_next[I2CMS_F_TXE] = 1'b0;
				end
				I2CMS_DIV_OFS: div_next = pwdata[15:0];
				default: ;
			endcase
		end
		// hardware clears by later bus events
		if (start_det) begin
			flg_next[I2CMS_F_STP] = 1'b0; // RULE_04
			flg_next[I2CMS_F_NACK] = 1'b0; // RULE_04
		end
		if (stop_det) begin
			flg_next[I2CMS_F_STT] = 1'b0; // RULE_04
		end
		case (st_reg)
			I2CMS_IDLE: begin
				sclo_next = 1'b1;
				sdao_next = 1'b1;
				// busy bus: park, only watch for release
				if (stt_reg && mm_reg && tr_reg && bus_busy) begin
					st_next = I2CMS_WAIT; // RULE_01
				end else if (stt_reg && !bus_busy) begin
					st_next = I2CMS_STA;
					cnt_next = div_reg;
				end
			end
			I2CMS_WAIT: begin
				// no transmit-empty updates from foreign clocks here
				if (!bus_busy) begin
					st_next = I2CMS_STA; // RULE_01 RULE_08
					cnt_next = div_reg;
				end
			end
			I2CMS_STA: begin
				sdao_next = 1'b0; // data low while clock high
				if (tick) begin
					stt_next = 1'b0; // RULE_02
					sclo_next = 1'b0;
					sdao_next = txb_reg[7]; // first bit set in the same cycle as the clock falls
					st_next = I2CMS_XFER;
					bit_next = 4'h0;
					ph_next = 1'b0;
					sh_next = txb_reg;
					txf_next = 1'b0; // RULE_08
					flg_next[I2CMS_F_TXE] = 1'b1; // byte taken
				end
			end
			I2CMS_XFER: begin
				// data only moves with the falling clock, never while high
				if (tick) begin
					ph_next = ~ph_reg;
					sclo_next = ~ph_reg;
					if (ph_reg && bit_reg == 4'h8) begin
						if (ls.sda) begin
							flg_next[I2CMS_F_NACK] = 1'b1;
							sdao_next = 1'b0; // prepare stop
							st_next = I2CMS_STO;
						end else if (txf_reg && !stp_reg) begin
							sh_next = txb_reg;
							sdao_next = txb_reg[7];
							txf_next = 1'b0;
							flg_next[I2CMS_F_TXE] = 1'b1;
							bit_next = 4'h0;
						end else begin
							sdao_next = 1'b0; // prepare stop
							st_next = I2CMS_STO;
						end
					end else if (ph_reg) begin
						sh_next = {sh_reg[6:0], 1'b0};
						sdao_next = (bit_reg == 4'h7) ? 1'b1 : sh_reg[6];
						bit_next = bit_reg + 4'h1;
					end
				end
			end
			I2CMS_STO: begin
				if (tick) begin
					if (sclo_reg) begin
						sdao_next = 1'b1;
						stp_next = 1'b0;
						st_next = I2CMS_IDLE;
					end else begin
						sdao_next = 1'b0;
						sclo_next = 1'b1;
					end
				end
			end
			default: st_next = I2CMS_IDLE;
		endcase
		// sticky sets win over software clear
		if (start_det) begin
			flg_next[I2CMS_F_STT] = 1'b1;
		end
		if (stop_det) begin
			flg_next[I2CMS_F_STP] = 1'b1;
		end
		// pins come straight from flops; high pulls the line low
		scl_oe_next = ~sclo_next;
		sda_oe_next = ~sdao_next;
		// pending needs flag, enable and global enable
		irq_next = gie_next & |(flg_next & ien_next); // RULE_05
	end
	// registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mm_reg <= 1'b0;
			tr_reg <= 1'b0;
			stt_reg <= 1'b0;
			stp_reg <= 1'b0;
			gie_reg <= 1'b0;
			ien_reg <= I2CMS_IEN_RST;
			flg_reg <= I2CMS_FLAG_RST;
			txb_reg <= 8'h00;
			txf_reg <= 1'b0;
			div_reg <= I2CMS_DIV_RST;
			cnt_reg <= I2CMS_DIV_RST;
			st_reg <= I2CMS_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			ph_reg <= 1'b0;
			sclo_reg <= 1'b1;
			sdao_reg <= 1'b1;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
		end else begin
			mm_reg <= mm_next;
			tr_reg <= tr_next;
			stt_reg <= stt_next;
			stp_reg <= stp_next;
			gie_reg <= gie_next;
			ien_reg <= ien_next;
			flg_reg <= flg_next;
			txb_reg <= txb_next;
			txf_reg <= txf_next;
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			st_reg <= st_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			ph_reg <= ph_next;
			sclo_reg <= sclo_next;
			sdao_reg <= sdao_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			rd_reg <= rd_next;
			irq_reg <= irq_next;
		end
	end
	// open drain: drive only zeros; one-cycle apb answer
	assign prdata = rd_reg;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign irq = irq_reg;
	////////////////////////////////////////////////////////////////////////
	// checks
	a_wait_no_start: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg == I2CMS_WAIT |-> stt_reg && sdao_reg) // RULE_01
		else $error("start driven while waiting");
	a_stt_holds: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(stt_reg) |-> $past(st_reg) == I2CMS_STA) // RULE_02
		else $error("start request dropped early");
	a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
		stop_det |=> !flg_reg[I2CMS_F_STT]) // RULE_04
		else $error("start flag kept past stop");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == (gie_reg && |(flg_reg & ien_reg))) // RULE_05
		else $error("irq mismatch");
	a_wait_keeps_tx: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg == I2CMS_WAIT && !wr |=> $stable(txf_reg)
		&& $stable(flg_reg[I2CMS_F_TXE])) // RULE_08
		else $error("tx state changed while waiting");
endmodule : i2cms_top
`default_nettype wire

// *** dv/i2cms_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
// another master on the shared bus; its clock runs only inside frames
module i2cms_peer (
	output logic scl_oe,
	output logic sda_oe
);
	// half period of the 64 ns link clock
	localparam time HALF = 32;
	// lines released until a frame is asked for
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// one frame of nbits; data alternates and is never acked
	task automatic traffic(input int nbits);
		#3; // keep pin moves off the system clock edge
		sda_oe = 1'b1; // start: data falls while clock is high
		#HALF;
		for (int i = 0; i < nbits; i++) begin
			scl_oe = 1'b1;
			#(HALF / 2);
			sda_oe = i[0]; // data moves only while clock is low
			#(HALF / 2);
			scl_oe = 1'b0;
			#HALF;
		end
		scl_oe = 1'b1;
		sda_oe = 1'b1;
		#HALF;
		scl_oe = 1'b0; // stop: clock released first, then data
		#HALF;
		sda_oe = 1'b0;
	endtask : traffic
endmodule : i2cms_peer
`default_nettype wire

// *** dv/i2cms_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2cms_top_tb;
	import i2cms_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, got;
	logic [31:0] pwdata, prdata, rd;
	logic scl_out, scl_oe, sda_out, sda_oe, p_scl_oe, p_sda_oe;
	logic scl_w, sda_w; // wired-and lines with pull-ups
	int err_total, checks_done;
	assign scl_w = ~(scl_oe | p_scl_oe);
	assign sda_w = ~(sda_oe | p_sda_oe);
	i2cms_top i2cms_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	i2cms_peer i2cms_peer_inst (.scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
	////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; read data lands in rd
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// read until bit b equals v, bounded, then compare
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		apb(1'b0, a, 32'h0000_0000);
		while (rd[b] !== v && n < 400) begin
			apb(1'b0, a, 32'h0000_0000);
			n++;
		end
		chk(32'(rd[b]), 32'(v));
	endtask : poll
	// collect the first eight bits the block clocks out, msb first
	task automatic cap_byte;
		got = 8'h00;
		repeat (8) begin
			@(posedge scl_w);
			got = {got[6:0], sda_w};
		end
	endtask : cap_byte
	////////////////////////////////////////////////////////////////////
	// reset values and an unmapped place
	task automatic t_reset;
		apb(1'b0, I2CMS_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
		chk(rd, 32'(I2CMS_FLAG_RST));
		apb(1'b0, I2CMS_DIV_OFS, 32'h0000_0000);
		chk(rd, 32'(I2CMS_DIV_RST));
		chk(32'({pslverr, scl_out, sda_out}), 32'h0000_0000);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset
	// start asked while another master owns the bus
	task automatic t_wait_start;
		apb(1'b1, I2CMS_DIV_OFS, 32'h0000_0004);
		apb(1'b1, I2CMS_TXD_OFS, 32'h0000_00A5);
		apb(1'b1, I2CMS_CTRL_OFS, 32'h0000_0003);
		fork
			begin
				i2cms_peer_inst.traffic(18);
				cap_byte();
			end
			begin
				poll(I2CMS_STAT_OFS, I2CMS_BUSY_BIT, 1'b1);
				apb(1'b1, I2CMS_CTRL_OFS, 32'h0000_0007);
				repeat (6) begin
					apb(1'b0, I2CMS_CTRL_OFS, 32'h0000_0000);
					chk(32'(rd[I2CMS_CTRL_STT_BIT]), 32'h1);
					chk(32'({scl_oe, sda_oe}), 32'h0);
					apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
					chk(32'(rd[I2CMS_F_TXE]), 32'h0);
				end
				// next load waits for the request to read zero
				poll(I2CMS_CTRL_OFS, I2CMS_CTRL_STT_BIT, 1'b0);
				apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
				chk(32'(rd[I2CMS_F_STP]), 32'h0);
				chk(32'(rd[I2CMS_F_TXE]), 32'h1);
			end
		join
		chk(32'(got), 32'h0000_00A5);
		$display("test wait start done");
	endtask : t_wait_start
	// nack flag, enables and the global gate
	task automatic t_irq;
		poll(I2CMS_STAT_OFS, I2CMS_F_NACK, 1'b1);
		apb(1'b1, I2CMS_IEN_OFS, 32'h0000_0004);
		apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
		chk(32'(irq), 32'h0);
		apb(1'b1, I2CMS_IEN_OFS, 32'h0000_0000);
		apb(1'b1, I2CMS_CTRL_OFS, 32'h0000_0013);
		apb(1'b1, I2CMS_IEN_OFS, 32'h0000_0004);
		apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
		chk(32'(irq), 32'h1);
		apb(1'b1, I2CMS_ICLR_OFS, 32'h0000_0004);
		apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
		chk(32'(rd[I2CMS_F_NACK]), 32'h0);
		chk(32'(irq), 32'h0);
		// no repeated start is issued here
		apb(1'b1, I2CMS_CTRL_OFS, 32'h0000_001B);
		poll(I2CMS_STAT_OFS, I2CMS_BUSY_BIT, 1'b0);
		$display("test irq done");
	endtask : t_irq
	// start flag set by a foreign start, cleared by its stop
	task automatic t_hw_clear;
		apb(1'b1, I2CMS_ICLR_OFS, 32'h0000_0007);
		apb(1'b1, I2CMS_IEN_OFS, 32'h0000_0001);
		fork
			i2cms_peer_inst.traffic(4);
			begin
				poll(I2CMS_STAT_OFS, I2CMS_F_STT, 1'b1);
				chk(32'(irq), 32'h1);
			end
		join
		poll(I2CMS_STAT_OFS, I2CMS_F_STT, 1'b0);
		chk(32'(rd[I2CMS_F_STP]), 32'h1);
		apb(1'b0, I2CMS_STAT_OFS, 32'h0000_0000);
		chk(32'(irq), 32'h0);
		$display("test hw clear done");
	endtask : t_hw_clear
	////////////////////////////////////////////////////////////////////
	// counts, verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// free-running system clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// watchdog far beyond the few hundred cycles the tests take
	initial begin
		#200us;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	// main sequence
	initial begin
		err_total = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_wait_start();
		t_irq();
		t_hw_clear();
		tally_and_finish();
	end
endmodule : i2cms_top_tb
`default_nettype wire
